// File: pkg/trf_map.svh
// register map, field positions, codes and counts of the response framer
`ifndef TRF_MAP_SVH
`define TRF_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TRF_OFS_CONTROL 12'h000
`define TRF_OFS_BLOCK_LENGTH 12'h004
`define TRF_OFS_STATUS 12'h008
`define TRF_OFS_ACCEPT_COUNT 12'h00c
`define TRF_OFS_REJECT_COUNT 12'h010
`define TRF_OFS_READ_DATA0 12'h020
`define TRF_OFS_READ_DATA1 12'h024
`define TRF_OFS_READ_DATA2 12'h028
`define TRF_OFS_READ_DATA3 12'h02c
// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define TRF_CTL_TWO_LANE 0
`define TRF_CTL_NODE_LSB 4
`define TRF_CTL_NODE_MSB 7
`define TRF_RST_TWO_LANE 1'h0
`define TRF_RST_NODE_ID 4'h1
`define TRF_RST_BLOCK_LENGTH 16'h0200
// status bits and the top bit of the 16-bit fields
`define TRF_STS_BUSY 0
`define TRF_STS_REJECT 1
`define TRF_STS_CODE_LSB 4
`define TRF_STS_CODE_MSB 6
`define TRF_HALF_MSB 15
// ----------------------------------------------------------------
// transfer mode bit positions
// ----------------------------------------------------------------
`define TRF_TM_DUPLEX 3
`define TRF_TM_LENGTH 2
`define TRF_TM_UNIT 1
`define TRF_TM_FIXED 0
// ----------------------------------------------------------------
// error categories
// ----------------------------------------------------------------
`define TRF_ERR_NONE 3'h0
`define TRF_ERR_STATE 3'h1
`define TRF_ERR_ARGUMENT 3'h2
`define TRF_ERR_GENERAL 3'h3
// ----------------------------------------------------------------
// payload length codes and packet sizes
// ----------------------------------------------------------------
`define TRF_PAYLOAD_LENGTH_CODE_ZERO 2'h0
`define TRF_PAYLOAD_LENGTH_CODE_ONE 2'h1
`define TRF_PAYLOAD_LENGTH_CODE_TWO 2'h2
`define TRF_RSP_HEAD_BYTES 5'h04
`define TRF_DWORD_BYTES 5'h04
`define TRF_RSP_MAX_BYTES 20
`define TRF_DWORD_BITS 6'h20
`endif

// File: pkg/trf_pkg.sv
// types shared by the response framer
package trf_pkg;
	// response sender phases
	typedef enum logic [0:0] {
		RSP_IDLE,
		RSP_SEND
	} trf_rsp_e;
	// one decoded command as delivered by the link layer
	typedef struct packed {
		logic isData; // data command, else control command
		logic isWrite; // write direction
		logic broadcast; // broadcast control packet
		logic forward; // addressed to another node
		logic [3:0] sourceNodeId; // requester node
		logic [2:0] transactionId; // transaction number
		logic [1:0] payloadLengthCode; // control payload length code
		logic [3:0] transferModeBits; // duplex, length, unit, fixed
		logic [31:0] transferLength; // length field when present
		logic [3:0][7:0] argumentBytes; // raw argument bytes
		logic stateError; // issued in an improper state
		logic argumentError; // other improper argument found
		logic generalError; // any other error
	} trf_cmd_s;
	// complete state of the framer
	typedef struct packed {
		trf_rsp_e rspState;
		logic [19:0][7:0] rspBuffer;
		logic [4:0] rspIndex;
		logic [4:0] rspCount;
		logic [7:0] respByte;
		logic respValid;
		logic respLast;
		logic cmdReady;
		logic forwardValid;
		trf_cmd_s forwardCmd;
		logic dataStart;
		logic dataWrite;
		logic [31:0] dataLength;
		logic [31:0] dataShift;
		logic [5:0] dataBits;
		logic dataBitValid;
		logic dataWordReady;
		logic twoLane;
		logic [3:0] nodeId;
		logic [15:0] blockLength;
		logic [3:0][31:0] readData;
		logic lastReject;
		logic [2:0] lastCode;
		logic [15:0] acceptCount;
		logic [15:0] rejectCount;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} trf_state_s;
endpackage

// File: rtl/trf_response_framer.sv
// command check, response packet builder and data bit serializer
//
// Notes on behaviour
// [RULE_01] only five transfer-mode patterns are accepted
// [RULE_02] fixed-address data access is always rejected
// [RULE_03] byte units need a transfer length
// [RULE_04] two-lane duplex with byte units rejected
// [RULE_05] reject flag zero on accept, one on reject
// [RULE_06] accept only commands now executing or queued
// [RULE_07] reject means an error stopped execution
// [RULE_08] accept echoes second and third argument bytes
// [RULE_09] control read payload follows length code
// [RULE_10] no payload for writes or data commands
// [RULE_11] payload sent as big-endian double words
// [RULE_12] destination is requester, transaction number kept
// [RULE_13] reject carries a three-bit error category
// [RULE_14] smallest error category wins
// [RULE_15] data length is block or transfer length
// [RULE_16] data least byte first, msb first
// [RULE_17] reserved bits driven zero except echo
// [RULE_18] forwarded packets keep reserved bits untouched
// [RULE_19] host uses reserved bits all nodes tolerate
// [RULE_20] two-lane request rejected when unsupported
// [RULE_21] byte units without length is argument error
// [RULE_22] never emit a reserved error category
// [RULE_23] rejected modes start no data transfer
`timescale 1ns/1ns
`include "trf_map.svh"
module trf_response_framer
	import trf_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// decoded command from the link layer
	input wire logic cmdValid,
	input wire trf_cmd_s cmdIn,
	output logic cmdReady,
	// command passed on to the next node
	output logic forwardValid,
	output trf_cmd_s forwardCmd,
	// response byte stream
	output logic [7:0] respByte,
	output logic respValid,
	output logic respLast,
	input wire logic respReady,
	// data transfer grant
	output logic dataStart,
	output logic dataWrite,
	output logic [31:0] dataLength,
	// data payload serializer
	input wire logic dataWordValid,
	input wire logic [31:0] dataWord,
	output logic dataWordReady,
	output logic dataBit,
	output logic dataBitValid
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	trf_state_s state; // registered state
	trf_state_s next_state; // next value of the state
	logic setupPhase; // apb setup cycle
	logic accessDone; // apb access completes this edge
	logic addrMapped; // address hits a register
	logic [31:0] readMux; // register read value
	logic cmdTaken; // command accepted into the framer
	logic modeError; // unavailable transfer mode
	logic argError; // any argument category error
	logic [2:0] errorCategory; // chosen error category
	logic rejectFlag; // response rejects the command
	logic [2:0] payloadWords; // read payload double words
	logic [4:0] byteIndex; // buffer index in fill loop
	logic [31:0] swappedWord; // word in bit transmit order
	logic respondNeeded; // command answers with a response
	logic dmBit; // duplex select
	logic lmBit; // length present
	logic tlumBit; // length unit select
	logic damBit; // fixed address access

	// ----------------------------------------------------------------
	// register read decode
	// ----------------------------------------------------------------
	// read mux, reserved bits zero
	always_comb begin
		addrMapped = 1'b1;
		readMux = 32'h0000_0000;
		case (paddr)
			`TRF_OFS_CONTROL: begin
				readMux[`TRF_CTL_TWO_LANE] = state.twoLane;
				readMux[`TRF_CTL_NODE_MSB:`TRF_CTL_NODE_LSB] = state.nodeId;
			end
			`TRF_OFS_BLOCK_LENGTH: begin
				readMux[`TRF_HALF_MSB:0] = state.blockLength;
			end
			`TRF_OFS_STATUS: begin
				// busy, last reject flag and category
				readMux[`TRF_STS_BUSY] = (state.rspState == RSP_SEND);
				readMux[`TRF_STS_REJECT] = state.lastReject;
				readMux[`TRF_STS_CODE_MSB:`TRF_STS_CODE_LSB] = state.lastCode;
			end
			`TRF_OFS_ACCEPT_COUNT: begin
				readMux[`TRF_HALF_MSB:0] = state.acceptCount;
			end
			`TRF_OFS_REJECT_COUNT: begin
				readMux[`TRF_HALF_MSB:0] = state.rejectCount;
			end
			`TRF_OFS_READ_DATA0: begin
				readMux = state.readData[0];
			end
			`TRF_OFS_READ_DATA1: begin
				readMux = state.readData[1];
			end
			`TRF_OFS_READ_DATA2: begin
				readMux = state.readData[2];
			end
			`TRF_OFS_READ_DATA3: begin
				readMux = state.readData[3];
			end
			default: begin
				// unmapped address answers with an error
				addrMapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// command check
	// ----------------------------------------------------------------
	// transfer mode decode and error ranking
	always_comb begin
		dmBit = cmdIn.transferModeBits[`TRF_TM_DUPLEX];
		lmBit = cmdIn.transferModeBits[`TRF_TM_LENGTH];
		tlumBit = cmdIn.transferModeBits[`TRF_TM_UNIT];
		damBit = cmdIn.transferModeBits[`TRF_TM_FIXED];
		modeError = 1'b0;
		if (cmdIn.isData) begin
			// patterns outside the available set
			if (damBit) begin
				modeError = 1'b1; // [RULE_02] [RULE_01]
			end
			if (tlumBit && !lmBit) begin
				modeError = 1'b1; // [RULE_03] [RULE_21]
			end
			if (dmBit && tlumBit) begin
				modeError = 1'b1; // [RULE_04]
			end
			if (dmBit && !state.twoLane) begin
				modeError = 1'b1; // [RULE_20]
			end
			// zero or oversize byte length counts as missing
			if (tlumBit && lmBit && ((cmdIn.transferLength == 32'h0) ||
					(cmdIn.transferLength > {16'h0, state.blockLength}))) begin
				modeError = 1'b1; // [RULE_21]
			end
		end
		argError = modeError || cmdIn.argumentError;
		// smallest category reported, only defined codes
		if (cmdIn.stateError) begin
			errorCategory = `TRF_ERR_STATE; // [RULE_14] [RULE_13]
		end else if (argError) begin
			errorCategory = `TRF_ERR_ARGUMENT; // [RULE_14] [RULE_13]
		end else if (cmdIn.generalError) begin
			errorCategory = `TRF_ERR_GENERAL; // [RULE_13] [RULE_22]
		end else begin
			errorCategory = `TRF_ERR_NONE;
		end
		rejectFlag = (errorCategory != `TRF_ERR_NONE); // [RULE_07]
		// read payload size from the length code
		case (cmdIn.payloadLengthCode)
			`TRF_PAYLOAD_LENGTH_CODE_ZERO: payloadWords = 3'h0;
			`TRF_PAYLOAD_LENGTH_CODE_ONE: payloadWords = 3'h1;
			`TRF_PAYLOAD_LENGTH_CODE_TWO: payloadWords = 3'h2;
			default: payloadWords = 3'h4;
		endcase
		// bytes reordered so bit 7 of the low byte goes first
		swappedWord = {dataWord[7:0], dataWord[15:8],
			dataWord[23:16], dataWord[31:24]}; // [RULE_16]
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// all state updates
	always_comb begin
		next_state = state;
		byteIndex = 5'h00;
		setupPhase = psel && !penable;
		accessDone = psel && penable && state.pready;
		cmdTaken = cmdValid && state.cmdReady;
		respondNeeded = !cmdIn.forward && !cmdIn.broadcast;
		// one-cycle pulses drop by default
		next_state.forwardValid = 1'b0;
		next_state.dataStart = 1'b0;
		// apb: ready one cycle after setup
		if (setupPhase) begin
			next_state.pready = 1'b1;
			next_state.pslverr = !addrMapped;
			next_state.prdata = readMux;
		end else if (accessDone) begin
			next_state.pready = 1'b0;
			next_state.pslverr = 1'b0;
			if (pwrite) begin
				case (paddr)
					`TRF_OFS_CONTROL: begin
						next_state.twoLane = pwdata[`TRF_CTL_TWO_LANE];
						next_state.nodeId =
							pwdata[`TRF_CTL_NODE_MSB:`TRF_CTL_NODE_LSB];
					end
					`TRF_OFS_BLOCK_LENGTH: begin
						next_state.blockLength = pwdata[`TRF_HALF_MSB:0];
					end
					`TRF_OFS_READ_DATA0: next_state.readData[0] = pwdata;
					`TRF_OFS_READ_DATA1: next_state.readData[1] = pwdata;
					`TRF_OFS_READ_DATA2: next_state.readData[2] = pwdata;
					`TRF_OFS_READ_DATA3: next_state.readData[3] = pwdata;
					default: begin
						// counters and status are read only
					end
				endcase
			end
		end
		case (state.rspState)
			RSP_IDLE: begin
				if (cmdTaken && !respondNeeded) begin
					// pass through, reserved bits untouched
					next_state.forwardValid = 1'b1; // [RULE_18]
					next_state.forwardCmd = cmdIn; // [RULE_18]
				end else if (cmdTaken) begin
					// header: requester becomes destination
					next_state.rspBuffer = '0; // [RULE_17]
					next_state.rspBuffer[0] =
						{cmdIn.sourceNodeId, state.nodeId}; // [RULE_12]
					next_state.rspBuffer[1] =
						{5'h00, cmdIn.transactionId}; // [RULE_12]
					next_state.rspCount = `TRF_RSP_HEAD_BYTES;
					if (rejectFlag) begin
						// reject: flag and category, rest zero
						next_state.rspBuffer[2] = 8'h80; // [RULE_05]
						next_state.rspBuffer[3] =
							{5'h00, errorCategory}; // [RULE_13]
						next_state.rejectCount = state.rejectCount + 16'h1;
					end else begin
						// accept: flag low and argument echo
						next_state.rspBuffer[2] = {1'b0,
							cmdIn.argumentBytes[1][6:0]}; // [RULE_05] [RULE_08]
						next_state.rspBuffer[3] =
							cmdIn.argumentBytes[2]; // [RULE_08]
						next_state.acceptCount = state.acceptCount + 16'h1;
						if (!cmdIn.isData && !cmdIn.isWrite) begin
							// read data as big-endian double words
							for (int w = 0; w < 4; w++) begin
								if (w < int'(payloadWords)) begin
									for (int k = 0; k < 4; k++) begin
										byteIndex = 5'(4 + 4 * w + k);
										next_state.rspBuffer[byteIndex] =
											state.readData[w][31 - 8 * k -: 8]; // [RULE_11]
									end
								end
							end
							next_state.rspCount = `TRF_RSP_HEAD_BYTES +
								5'(payloadWords) * `TRF_DWORD_BYTES; // [RULE_09]
						end
						// writes and data commands end at header, [RULE_10]
						if (cmdIn.isData) begin
							// grant the transfer only once accepted
							next_state.dataStart = 1'b1; // [RULE_23] [RULE_06]
							next_state.dataWrite = cmdIn.isWrite;
							next_state.dataLength =
								cmdIn.transferModeBits[`TRF_TM_UNIT] ?
								cmdIn.transferLength :
								{16'h0, state.blockLength}; // [RULE_15]
						end
					end
					next_state.lastReject = rejectFlag;
					next_state.lastCode = errorCategory;
					next_state.respByte = next_state.rspBuffer[0];
					next_state.respValid = 1'b1;
					next_state.respLast = 1'b0;
					next_state.rspIndex = 5'h01;
					next_state.rspState = RSP_SEND;
				end
			end
			RSP_SEND: begin
				// advance one byte per accepted handshake
				if (state.respValid && respReady) begin
					if (state.rspIndex == state.rspCount) begin
						next_state.respValid = 1'b0;
						next_state.respLast = 1'b0;
						next_state.respByte = 8'h00;
						next_state.rspState = RSP_IDLE;
					end else begin
						next_state.respByte = state.rspBuffer[state.rspIndex];
						next_state.respLast =
							(state.rspIndex == state.rspCount - 5'h01);
						next_state.rspIndex = state.rspIndex + 5'h01;
					end
				end
			end
			default: begin
				next_state.rspState = RSP_IDLE;
			end
		endcase
		next_state.cmdReady = (next_state.rspState == RSP_IDLE) &&
			!(cmdTaken && respondNeeded);
		// data serializer: one bit per clock
		if (state.dataBitValid) begin
			next_state.dataShift = {state.dataShift[30:0], 1'b0}; // [RULE_16]
			next_state.dataBits = state.dataBits - 6'h01;
			if (state.dataBits == 6'h01) begin
				next_state.dataBitValid = 1'b0;
				next_state.dataWordReady = 1'b1;
			end
		end else if (dataWordValid && state.dataWordReady) begin
			next_state.dataShift = swappedWord; // [RULE_16]
			next_state.dataBits = `TRF_DWORD_BITS;
			next_state.dataBitValid = 1'b1;
			next_state.dataWordReady = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset values, then register the next state
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= '0;
			state.rspState <= RSP_IDLE;
			state.cmdReady <= 1'b1;
			state.dataWordReady <= 1'b1;
			state.twoLane <= `TRF_RST_TWO_LANE;
			state.nodeId <= `TRF_RST_NODE_ID;
			state.blockLength <= `TRF_RST_BLOCK_LENGTH;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from the state register
	// ----------------------------------------------------------------
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign prdata = state.prdata;
	assign cmdReady = state.cmdReady;
	assign forwardValid = state.forwardValid;
	assign forwardCmd = state.forwardCmd;
	assign respByte = state.respByte;
	assign respValid = state.respValid;
	assign respLast = state.respLast;
	assign dataStart = state.dataStart;
	assign dataWrite = state.dataWrite;
	assign dataLength = state.dataLength;
	assign dataWordReady = state.dataWordReady;
	assign dataBit = state.dataShift[31];
	assign dataBitValid = state.dataBitValid;
endmodule

// File: bench/trf_response_framer_assertions.sv
// concurrent checks on the response framer ports
`timescale 1ns/1ns
module trf_response_framer_assertions
	import trf_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic cmdValid,
	input wire trf_cmd_s cmdIn,
	input wire logic cmdReady,
	input wire logic forwardValid,
	input wire trf_cmd_s forwardCmd,
	input wire logic [7:0] respByte,
	input wire logic respValid,
	input wire logic respLast,
	input wire logic respReady,
	input wire logic dataStart,
	input wire logic dataWordValid,
	input wire logic [31:0] dataWord,
	input wire logic dataWordReady,
	input wire logic dataBit
);
	logic take; // command handshake
	logic [4:0] idx; // index of the byte on show
	logic rej; // reject flag of this response
	trf_cmd_s held; // command being answered
	logic [4:0] lastIdx; // index of the final byte
	assign take = cmdValid && cmdReady;
	assign lastIdx = (rej || held.isData || held.isWrite) ? 5'h03 :
		(held.payloadLengthCode == 2'h3) ? 5'h13 :
		5'h03 + {1'b0, held.payloadLengthCode, 2'h0};
	// ----------------------------------------------------------------
	// helper: track the response in flight
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			idx <= 5'h00;
			rej <= 1'b0;
			held <= '0;
		end else if (take) begin
			idx <= 5'h00;
			rej <= 1'b0;
			held <= cmdIn;
		end else if (respValid && respReady) begin
			idx <= idx + 5'h01;
			rej <= (idx == 5'h02) ? respByte[7] : rej;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_head;
		take && !cmdIn.forward && !cmdIn.broadcast |=> respValid &&
			!cmdReady && respByte[7:4] == $past(cmdIn.sourceNodeId);
	endproperty
	a_head: assert property (p_head) else $error("bad first byte");
	property p_tid;
		respValid && idx == 5'h01 |-> respByte == {5'h00, held.transactionId};
	endproperty
	a_tid: assert property (p_tid) else $error("bad tid byte");
	property p_echo;
		respValid && idx == 5'h02 && !respByte[7] |->
			respByte[6:0] == held.argumentBytes[1][6:0];
	endproperty
	a_echo: assert property (p_echo) else $error("bad echo");
	property p_code;
		respValid && idx == 5'h03 && rej |-> respByte inside {8'h01, 8'h02,
			8'h03} && (!held.stateError || respByte == 8'h01);
	endproperty
	a_code: assert property (p_code) else $error("bad code");
	property p_fixed;
		respValid && idx == 5'h02 && held.isData && held.transferModeBits[0]
			|-> respByte == 8'h80;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed taken");
	property p_unit;
		respValid && idx == 5'h03 && held.isData && !held.stateError &&
			held.transferModeBits[1] && !held.transferModeBits[2]
			|-> rej && respByte == 8'h02;
	endproperty
	a_unit: assert property (p_unit) else $error("unit no len");
	property p_last;
		respValid && respLast |-> idx == lastIdx;
	endproperty
	a_last: assert property (p_last) else $error("bad length");
	property p_start;
		dataStart |-> $past(take) && held.isData && !held.transferModeBits[0]
			&& !(held.stateError || held.argumentError || held.generalError);
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_fwd;
		take && (cmdIn.forward || cmdIn.broadcast) |=> forwardValid &&
			forwardCmd == $past(cmdIn) && !respValid;
	endproperty
	a_fwd: assert property (p_fwd) else $error("bad forward");
	property p_ser;
		dataWordValid && dataWordReady |=> dataBit == $past(dataWord[7])
			##7 dataBit == $past(dataWord[0], 8)
			##1 dataBit == $past(dataWord[15], 9);
	endproperty
	a_ser: assert property (p_ser) else $error("bad bit order");
endmodule

// File: bench/trf_host_model.sv
// host model: issues commands and takes response bytes
`timescale 1ns/1ns
module trf_host_model
	import trf_pkg::*;
(
	input wire logic clock,
	output logic cmdValid,
	output trf_cmd_s cmdIn,
	input wire logic cmdReady,
	input wire logic [7:0] respByte,
	input wire logic respValid,
	input wire logic respLast,
	output logic respReady
);
	logic [7:0] rx [0:31]; // bytes received
	int rxn; // count of bytes received
	initial begin
		cmdValid = 1'b0;
		cmdIn = '0;
		respReady = 1'b1;
	end
	// one command, then its response when one is due
	// waits have no limit here: a hang runs into the bench's cycle limit
	task automatic issue(input trf_cmd_s c, input bit want, input bit slow);
		rxn = 0;
		@(posedge clock);
		cmdValid <= 1'b1;
		cmdIn <= c;
		do begin
			@(posedge clock);
		end while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		cmdIn <= trf_cmd_s'(~c); // released lines keep no stale value
		while (want) begin
			@(posedge clock);
			if (respValid === 1'b1 && respReady) begin
				rx[rxn] = respByte;
				rxn++;
				if (respLast === 1'b1) break;
			end
			respReady <= slow ? ~respReady : 1'b1;
		end
		respReady <= 1'b1;
	endtask
endmodule

// File: bench/trf_response_framer_tb_top.sv
// self-checking bench of the response framer
`timescale 1ns/1ns
`include "trf_map.svh"
module trf_response_framer_tb_top
	import trf_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, dataLength, dataWord, lastLen;
	logic cmdValid, cmdReady, forwardValid, respValid, respLast, respReady;
	logic dataStart, dataWrite, dataWordValid, dataWordReady;
	logic dataBit, dataBitValid, lastWr;
	logic [7:0] respByte;
	trf_cmd_s cmdIn, forwardCmd, lastFwd;
	int bad_count, checks, cyc, starts, fwds;
	always #20 clock = ~clock;
	trf_response_framer dut_u (.clock(clock), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.cmdValid(cmdValid), .cmdIn(cmdIn), .cmdReady(cmdReady),
		.forwardValid(forwardValid), .forwardCmd(forwardCmd),
		.respByte(respByte), .respValid(respValid), .respLast(respLast),
		.respReady(respReady), .dataStart(dataStart), .dataWrite(dataWrite),
		.dataLength(dataLength), .dataWordValid(dataWordValid),
		.dataWord(dataWord), .dataWordReady(dataWordReady),
		.dataBit(dataBit), .dataBitValid(dataBitValid));
	trf_host_model host_u (.clock(clock), .cmdValid(cmdValid),
		.cmdIn(cmdIn), .cmdReady(cmdReady), .respByte(respByte),
		.respValid(respValid), .respLast(respLast), .respReady(respReady));
	// monitor of grants and forwards, plus the hang limit
	always @(posedge clock) begin
		cyc++;
		if (dataStart === 1'b1) begin
			starts++;
			lastLen = dataLength;
			lastWr = dataWrite;
		end
		if (forwardValid === 1'b1) begin
			fwds++;
			lastFwd = forwardCmd;
		end
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] rd(int k);
		return 32'h8c4a2e10 + k * 32'h01010101;
	endfunction
	// one apb transfer, waiting for pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// reset values, unmapped access, setup of length and read data
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		apb(1'b0, `TRF_OFS_CONTROL, 32'h0, r, e);
		cmp("control", 32'h10, r);
		apb(1'b0, `TRF_OFS_BLOCK_LENGTH, 32'h0, r, e);
		cmp("block length", 32'h200, r);
		apb(1'b1, 12'h040, 32'h5, r, e);
		cmp("unmapped err", 32'h1, {31'h0, e});
		apb(1'b1, `TRF_OFS_BLOCK_LENGTH, 32'h20, r, e);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 12'(`TRF_OFS_READ_DATA0 + 4 * k), rd(k), r, e);
		end
	endtask
	// every transfer mode, with and without two-lane support
	task automatic t_modes();
		trf_cmd_s c;
		logic ok;
		logic [31:0] r;
		logic e;
		int s;
		for (int tl = 0; tl < 2; tl++) begin
			apb(1'b1, `TRF_OFS_CONTROL, 32'h10 | tl, r, e);
			for (int m = 0; m < 16; m++) begin
				c = '0;
				c.isData = 1'b1;
				c.isWrite = (tl == 1);
				c.sourceNodeId = 4'h6;
				c.transactionId = 3'(m);
				c.transferModeBits = 4'(m);
				c.transferLength = 32'h10;
				c.argumentBytes = 32'h00a55a3c;
				ok = !m[0] && !(m[1] && !m[2]) && !(m[1] && m[3]) && !(m[3] && tl == 0);
				s = starts;
				host_u.issue(c, 1'b1, m[2]);
				cmp("size", 32'd4, host_u.rxn);
				cmp("dest", 32'h61, host_u.rx[0]);
				cmp("tid", m & 7, host_u.rx[1]);
				cmp("flag", ok ? 8'h5a : 8'h80, host_u.rx[2]);
				cmp("code", ok ? 8'ha5 : 8'h02, host_u.rx[3]);
				cmp("start", {31'h0, ok}, starts - s);
				if (ok) cmp("len", m[1] ? 32'h10 : 32'h20, lastLen);
				if (ok) cmp("write", tl, {31'h0, lastWr});
			end
		end
	endtask
	// error priority on control writes
	task automatic t_prio();
		trf_cmd_s c;
		for (int k = 0; k < 3; k++) begin
			c = '0;
			c.isWrite = 1'b1;
			c.stateError = (k == 0);
			c.argumentError = (k < 2);
			c.generalError = (k > 0);
			host_u.issue(c, 1'b1, 1'b0);
			cmp("reject", 32'h80, host_u.rx[2]);
			cmp("priority", k + 1, host_u.rx[3]);
		end
	endtask
	// control reads of every payload length code
	task automatic t_read();
		trf_cmd_s c;
		int w;
		for (int p = 0; p < 4; p++) begin
			c = '0;
			c.payloadLengthCode = 2'(p);
			c.argumentBytes = 32'h00c3ff00;
			w = (p == 3) ? 4 : p;
			host_u.issue(c, 1'b1, p == 3);
			cmp("size", 4 + 4 * w, host_u.rxn);
			cmp("echo", 32'h7f, host_u.rx[2]);
			cmp("echo low", 32'hc3, host_u.rx[3]);
			for (int j = 0; j < 4 * w; j++) begin
				cmp("payload", (rd(j / 4) >> (24 - 8 * (j % 4))) & 32'hff,
					host_u.rx[4 + j]);
			end
		end
	endtask
	// forwarded and broadcast commands pass unchanged
	task automatic t_fwd();
		trf_cmd_s c;
		int f;
		for (int k = 0; k < 2; k++) begin
			c = '0;
			c.forward = (k == 0);
			c.broadcast = (k == 1);
			c.argumentBytes = 32'hdeadbeef;
			f = fwds;
			host_u.issue(c, 1'b0, 1'b0);
			repeat (2) @(posedge clock);
			cmp("fwd count", 32'h1, fwds - f);
			cmp("fwd copy", 32'h1, {31'h0, lastFwd === c});
		end
	endtask
	// one word through the bit serializer
	task automatic t_ser();
		logic [31:0] w;
		w = 32'h8421c3a5;
		@(posedge clock);
		dataWordValid <= 1'b1;
		dataWord <= w;
		do begin
			@(posedge clock);
		end while (dataWordReady !== 1'b1);
		dataWordValid <= 1'b0;
		dataWord <= ~w;
		for (int i = 0; i < 32; i++) begin
			@(posedge clock);
			cmp("bit", {30'h0, 1'b1, w[8 * (i / 8) + 7 - (i % 8)]},
				{30'h0, dataBitValid, dataBit});
		end
	endtask
	task automatic close_out();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		dataWordValid = 1'b0;
		dataWord = 32'h0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_regs();
		t_modes();
		t_prio();
		t_read();
		t_fwd();
		t_ser();
		close_out();
	end
endmodule
bind trf_response_framer trf_response_framer_assertions chk_u (
	.clock(clock), .reset(reset), .cmdValid(cmdValid), .cmdIn(cmdIn),
	.cmdReady(cmdReady), .forwardValid(forwardValid),
	.forwardCmd(forwardCmd), .respByte(respByte), .respValid(respValid),
	.respLast(respLast), .respReady(respReady), .dataStart(dataStart),
	.dataWordValid(dataWordValid), .dataWord(dataWord),
	.dataWordReady(dataWordReady), .dataBit(dataBit));
